// ===== src/cfx_name_chk.sv
// name length, masking and reserved-name decode
`timescale 1ns/10ps
`include "cfx_params.svh"
module cfx_name_chk (
    // raw name
    input wire logic [`CFX_NAME_BITS-1:0] name,
    input wire logic [4:0] nameLen,
    // decode
    output logic lenOk,
    output logic [`CFX_NAME_BITS-1:0] nameKey,
    output logic isCurrent,
    output logic isNext
);
    // ==========================================================
    // length and reserved names
    assign lenOk = (nameLen != 5'h00) && (nameLen <= `CFX_NAME_MAX);
    for (genvar i = 0; i < 16; i++) begin : gMask
        assign nameKey[i*8 +: 8] = (5'(i) < nameLen) ? name[i*8 +: 8] : 8'h00;
    end
    assign isCurrent = (nameLen == `CFX_CURRENT_LEN) && (nameKey[55:0] == `CFX_CURRENT_KEY);
    assign isNext = (nameLen == `CFX_NEXT_LEN) && (nameKey[31:0] == `CFX_NEXT_KEY);
endmodule // cfx_name_chk

// ===== src/cfx_params.svh
// constants and contract for the configuration exchange handler
//
// Contract
// - name length is 1 to 16 characters; others are refused
// - CURRENT and NEXT never name a new configuration
// - a name identifies exactly one stored configuration
// - stored configurations are only created or deleted, never changed
// - creation only under a name not yet defined here
// - store a definition only when it arrived entirely error free
// - a definition session opens with DEF announcing per-category counts
// - items arrive as sub-channels, streams, components, services, FIG files
// - on a detected error the open session is aborted and cause reported
// - an aborted creation is discarded entirely
// - only the session opener closes it, with END
// - DEL removes the named configuration from the local store
// - INF is answered by a DEF/END session or by ERR
// - INF CURRENT returns the configuration now on air
// - INF NEXT returns the pending one, else an error
// - either side may request definitions and answer such requests; this handler only answers INF and never sends a request itself
// - ERR aborts an open session and reports other message errors
// - END only after all announced items have been sent; INF answers here send END right after DEF, with no items
// - sub-channel count 0 to 64 and must match received items
// - unknown names in INF or DEL refused with the unknown cause
`ifndef CFX_PARAMS_SVH
`define CFX_PARAMS_SVH
`define CFX_NAME_MAX 5'h10
`define CFX_NAME_BITS 128
`define CFX_NCHAN_MAX 14'h40
`define CFX_NSTRM_MAX 14'h7FF
`define CFX_NCOMP_MAX 14'h270F
`define CFX_NSERV_MAX 14'h270F
`define CFX_NFIGF_MAX 14'h40
`define CFX_SLOTS 4
`define CFX_SLOT_W 2
`define CFX_CURRENT_KEY 56'h544E4552525543
`define CFX_CURRENT_LEN 5'h07
`define CFX_NEXT_KEY 32'h5458454E
`define CFX_NEXT_LEN 5'h04
`endif

// ===== src/cfx_pkg.sv
// types for the configuration exchange handler
`include "cfx_params.svh"
package cfx_pkg;
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_INF = 4'h1, CMD_DEF = 4'h2, CMD_END = 4'h3,
        CMD_DEL = 4'h4, CMD_ERR = 4'h5, CMD_SUBCHAN = 4'h6, CMD_USESTRM = 4'h7,
        CMD_CMPNENT = 4'h8, CMD_SERVICE = 4'h9, CMD_USEFIGF = 4'hA
    } cfx_cmd_t;
    typedef enum logic [3:0] {
        CAUSE_NONE = 4'h0, CAUSE_UNKNOWN = 4'h1, CAUSE_NOSPACE = 4'h2,
        CAUSE_USED = 4'h3, CAUSE_NCHAN = 4'h4, CAUSE_NSTRM = 4'h5,
        CAUSE_NCOMP = 4'h6, CAUSE_NSERV = 4'h7, CAUSE_NFIGF = 4'h8,
        CAUSE_SUBCHAN = 4'h9, CAUSE_USESTRM = 4'hA, CAUSE_CMPNENT = 4'hB,
        CAUSE_SERVICE = 4'hC, CAUSE_USEFIGF = 4'hD, CAUSE_BADNAME = 4'hE,
        CAUSE_NOSESS = 4'hF
    } cfx_cause_t;
    typedef enum logic [1:0] {
        RSP_ERR = 2'h0, RSP_DEF = 2'h1, RSP_END = 2'h2
    } cfx_kind_t;
    typedef enum logic {
        ST_IDLE = 1'b0, ST_RX = 1'b1
    } cfx_state_t;
    typedef struct packed {
        logic [13:0] chan;
        logic [13:0] strm;
        logic [13:0] comp;
        logic [13:0] serv;
        logic [13:0] figf;
    } cfx_counts_t;
    typedef struct packed {
        logic valid;
        cfx_cmd_t cmd;
        logic [4:0] nameLen;
        logic [`CFX_NAME_BITS-1:0] name;
        cfx_counts_t counts;
        logic itemOk;
    } cfx_msg_t;
    typedef struct packed {
        logic valid;
        cfx_kind_t kind;
        cfx_cause_t cause;
        logic [`CFX_NAME_BITS-1:0] name;
        cfx_counts_t counts;
    } cfx_rsp_t;
endpackage

// ===== src/cfx_session_handler.sv
// configuration exchange session handler, receive and answer side
`timescale 1ns/10ps
`include "cfx_params.svh"
module cfx_session_handler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // incoming messages
    input wire cfx_pkg::cfx_msg_t msgIn,
    output logic msgReady,
    // reconfiguration state
    input wire logic [`CFX_SLOT_W-1:0] onAirSlot,
    input wire logic reconfPending,
    input wire logic [`CFX_SLOT_W-1:0] nextSlot,
    // outgoing messages and status
    output cfx_pkg::cfx_rsp_t rspOut,
    output logic sessOpen,
    output logic [`CFX_SLOTS-1:0] slotUsed,
    output logic commitPulse
);
    import cfx_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [13:0] cntAt(cfx_counts_t c, logic [2:0] i);
        case (i)
            3'h0: cntAt = c.chan;
            3'h1: cntAt = c.strm;
            3'h2: cntAt = c.comp;
            3'h3: cntAt = c.serv;
            default: cntAt = c.figf;
        endcase
    endfunction

    function automatic cfx_cause_t cntCause(logic [2:0] i);
        case (i)
            3'h0: cntCause = CAUSE_NCHAN;
            3'h1: cntCause = CAUSE_NSTRM;
            3'h2: cntCause = CAUSE_NCOMP;
            3'h3: cntCause = CAUSE_NSERV;
            default: cntCause = CAUSE_NFIGF;
        endcase
    endfunction

    function automatic cfx_cause_t itemCause(logic [2:0] i);
        case (i)
            3'h0: itemCause = CAUSE_SUBCHAN;
            3'h1: itemCause = CAUSE_USESTRM;
            3'h2: itemCause = CAUSE_CMPNENT;
            3'h3: itemCause = CAUSE_SERVICE;
            default: itemCause = CAUSE_USEFIGF;
        endcase
    endfunction

    function automatic logic [2:0] itemStage(cfx_cmd_t c);
        case (c)
            CMD_SUBCHAN: itemStage = 3'h0;
            CMD_USESTRM: itemStage = 3'h1;
            CMD_CMPNENT: itemStage = 3'h2;
            CMD_SERVICE: itemStage = 3'h3;
            default: itemStage = 3'h4;
        endcase
    endfunction

    function automatic cfx_rsp_t mkErr(cfx_cause_t c, logic [`CFX_NAME_BITS-1:0] n);
        mkErr = '0;
        mkErr.valid = 1'b1;
        mkErr.kind = RSP_ERR;
        mkErr.cause = c;
        mkErr.name = n;
    endfunction

    // ==========================================================
    // state
    cfx_state_t state_ff, nxt_state;
    cfx_rsp_t rsp_ff, nxt_rsp;
    logic endPend_ff, nxt_endPend;
    logic msgReady_ff;
    logic commit_ff;
    logic [2:0] stage_ff, nxt_stage;
    logic [`CFX_NAME_BITS-1:0] sessName_ff;
    cfx_counts_t ann_ff;
    logic [4:0][13:0] rxCnt_ff;
    logic [`CFX_NAME_BITS-1:0] endName_ff;
    logic [`CFX_SLOTS-1:0] slotUsed_ff;
    logic [`CFX_NAME_BITS-1:0] slotName_ff [`CFX_SLOTS];
    cfx_counts_t slotCnt_ff [`CFX_SLOTS];
    logic openSess, cntInc, commitEn, delEn;

    // ==========================================================
    // decode
    wire take = msgIn.valid && msgReady_ff;
    wire isItem = (msgIn.cmd >= CMD_SUBCHAN) && (msgIn.cmd <= CMD_USEFIGF);
    wire [2:0] msgStg = itemStage(msgIn.cmd);
    wire lenOk, isCurrent, isNext;
    wire [`CFX_NAME_BITS-1:0] nameKey;
    wire reserved = isCurrent || isNext;

    cfx_name_chk uNameChk (
        .name(msgIn.name),
        .nameLen(msgIn.nameLen),
        .lenOk(lenOk),
        .nameKey(nameKey),
        .isCurrent(isCurrent),
        .isNext(isNext)
    );

    logic [`CFX_SLOTS-1:0] hitVec;
    logic hit, freeAny;
    logic [`CFX_SLOT_W-1:0] hitIdx, freeIdx;
    always_comb begin
        hitVec = '0;
        hit = 1'b0;
        hitIdx = '0;
        freeAny = 1'b0;
        freeIdx = '0;
        for (int i = 0; i < `CFX_SLOTS; i++) begin
            hitVec[i] = slotUsed_ff[i] && (slotName_ff[i] == nameKey);
            if (hitVec[i]) begin
                hit = 1'b1;
                hitIdx = `CFX_SLOT_W'(i);
            end
            if (!slotUsed_ff[i] && !freeAny) begin
                freeAny = 1'b1;
                freeIdx = `CFX_SLOT_W'(i);
            end
        end
    end

    // range of announced counts
    wire cfx_counts_t annIn = msgIn.counts;
    wire cfx_cause_t rangeCause =
        (annIn.chan > `CFX_NCHAN_MAX) ? CAUSE_NCHAN :
        (annIn.strm > `CFX_NSTRM_MAX) ? CAUSE_NSTRM :
        (annIn.comp > `CFX_NCOMP_MAX) ? CAUSE_NCOMP :
        (annIn.serv > `CFX_NSERV_MAX) ? CAUSE_NSERV :
        (annIn.figf > `CFX_NFIGF_MAX) ? CAUSE_NFIGF : CAUSE_NONE;

    // first category whose received count differs from the announcement
    cfx_cause_t mismCause;
    always_comb begin
        mismCause = CAUSE_NONE;
        for (int i = 4; i >= 0; i--) begin
            if (rxCnt_ff[i] != cntAt(ann_ff, 3'(i))) begin
                mismCause = cntCause(3'(i));
            end
        end
    end

    // definition request target
    wire [`CFX_SLOT_W-1:0] infIdx = isCurrent ? onAirSlot : isNext ? nextSlot : hitIdx;
    wire infOk = isCurrent ? slotUsed_ff[onAirSlot] :
        isNext ? (reconfPending && slotUsed_ff[nextSlot]) : (hit && lenOk);
    wire itemFull = rxCnt_ff[msgStg] == cntAt(ann_ff, msgStg);
    wire [`CFX_NAME_BITS-1:0] errName = (state_ff == ST_RX) ? sessName_ff : nameKey;

    // ==========================================================
    // message handling
    always_comb begin
        nxt_state = state_ff;
        nxt_rsp = '0;
        nxt_stage = stage_ff;
        nxt_endPend = 1'b0;
        openSess = 1'b0;
        cntInc = 1'b0;
        commitEn = 1'b0;
        delEn = 1'b0;
        if (endPend_ff) begin
            nxt_rsp.valid = 1'b1;
            nxt_rsp.kind = RSP_END;
            nxt_rsp.name = endName_ff;
        end else if (take) begin
            case (msgIn.cmd)
                CMD_INF: begin
                    if (infOk) begin
                        nxt_rsp.valid = 1'b1;
                        nxt_rsp.kind = RSP_DEF;
                        nxt_rsp.name = slotName_ff[infIdx];
                        nxt_rsp.counts = slotCnt_ff[infIdx];
                        nxt_endPend = 1'b1;
                    end else begin
                        nxt_rsp = mkErr(CAUSE_UNKNOWN, nameKey);
                    end
                end
                CMD_DEF: begin
                    if (state_ff == ST_RX) begin
                        nxt_rsp = mkErr(CAUSE_NOSESS, sessName_ff);
                    end else if (!lenOk || reserved) begin
                        nxt_rsp = mkErr(CAUSE_BADNAME, nameKey);
                    end else if (hit) begin
                        nxt_rsp = mkErr(CAUSE_USED, nameKey);
                    end else if (!freeAny) begin
                        nxt_rsp = mkErr(CAUSE_NOSPACE, nameKey);
                    end else if (rangeCause != CAUSE_NONE) begin
                        nxt_rsp = mkErr(rangeCause, nameKey);
                    end else begin
                        openSess = 1'b1;
                        nxt_state = ST_RX;
                        nxt_stage = 3'h0;
                    end
                end
                CMD_END: begin
                    if (state_ff != ST_RX) begin
                        nxt_rsp = mkErr(CAUSE_NOSESS, nameKey);
                    end else if (mismCause != CAUSE_NONE) begin
                        nxt_rsp = mkErr(mismCause, sessName_ff);
                    end else begin
                        commitEn = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
                CMD_DEL: begin
                    if (!hit || !lenOk || reserved) begin
                        nxt_rsp = mkErr(CAUSE_UNKNOWN, nameKey);
                    end else begin
                        delEn = 1'b1;
                    end
                end
                CMD_ERR: begin
                    nxt_state = ST_IDLE;
                end
                default: begin
                    if (isItem && state_ff != ST_RX) begin
                        nxt_rsp = mkErr(CAUSE_NOSESS, nameKey);
                    end else if (isItem && (msgStg < stage_ff || !msgIn.itemOk)) begin
                        nxt_rsp = mkErr(itemCause(msgStg), errName);
                    end else if (isItem && itemFull) begin
                        nxt_rsp = mkErr(cntCause(msgStg), errName);
                    end else if (isItem) begin
                        cntInc = 1'b1;
                        nxt_stage = msgStg;
                    end
                end
            endcase
            if (nxt_rsp.valid && nxt_rsp.kind == RSP_ERR) begin
                nxt_state = ST_IDLE;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            rsp_ff <= '0;
            stage_ff <= 3'h0;
            endPend_ff <= 1'b0;
            msgReady_ff <= 1'b1;
            commit_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rsp_ff <= nxt_rsp;
            stage_ff <= nxt_stage;
            endPend_ff <= nxt_endPend;
            msgReady_ff <= !nxt_endPend;
            commit_ff <= commitEn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sessName_ff <= '0;
            ann_ff <= '0;
            rxCnt_ff <= '0;
            endName_ff <= '0;
        end else begin
            if (openSess) begin
                sessName_ff <= nameKey;
                ann_ff <= msgIn.counts;
                rxCnt_ff <= '0;
            end else if (cntInc) begin
                rxCnt_ff[msgStg] <= rxCnt_ff[msgStg] + 14'h0001;
            end
            if (nxt_endPend) begin
                endName_ff <= slotName_ff[infIdx];
            end
        end
    end

    // store: written only on an error-free close, cleared only by delete or reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slotUsed_ff <= '0;
        end else if (commitEn) begin
            slotUsed_ff[freeIdx] <= 1'b1;
        end else if (delEn) begin
            slotUsed_ff[hitIdx] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (commitEn) begin
            slotName_ff[freeIdx] <= sessName_ff;
            slotCnt_ff[freeIdx] <= ann_ff;
        end
    end

    // ==========================================================
    // outputs
    assign rspOut = rsp_ff;
    assign msgReady = msgReady_ff;
    assign sessOpen = (state_ff == ST_RX);
    assign slotUsed = slotUsed_ff;
    assign commitPulse = commit_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    wire takeDef = take && msgIn.cmd == CMD_DEF && state_ff == ST_IDLE;

    name_len_a: assert property (takeDef && !lenOk |=> rsp_ff.cause == CAUSE_BADNAME)
        else $error("bad name length not refused");
    reserved_name_a: assert property (takeDef && reserved |=> !sessOpen && rsp_ff.valid)
        else $error("reserved name accepted");
    unique_hit_a: assert property ($onehot0(hitVec))
        else $error("name matches several slots");
    slot_stable_a: assert property (slotUsed_ff[0] && !(delEn && hitIdx == 2'h0) |=> $stable(slotName_ff[0]))
        else $error("stored configuration changed");
    dup_name_a: assert property (takeDef && lenOk && !reserved && hit |=> rsp_ff.cause == CAUSE_USED)
        else $error("duplicate name not refused");
    commit_cause_a: assert property (commitPulse |-> $past(state_ff) == ST_RX && !rsp_ff.valid)
        else $error("commit without clean close");
    err_abort_a: assert property (rsp_ff.valid && rsp_ff.kind == RSP_ERR |-> !sessOpen)
        else $error("session left open after error");
    chan_range_a: assert property (takeDef && msgIn.counts.chan > `CFX_NCHAN_MAX |=> !sessOpen ##0 rsp_ff.valid)
        else $error("sub-channel count not checked");
    inf_end_a: assert property (rsp_ff.valid && rsp_ff.kind == RSP_DEF |=> rsp_ff.valid && rsp_ff.kind == RSP_END && msgReady)
        else $error("definition answer not closed");
    next_none_a: assert property (take && msgIn.cmd == CMD_INF && isNext && !reconfPending |=> rsp_ff.cause == CAUSE_UNKNOWN)
        else $error("NEXT without pending not refused");
    del_clear_a: assert property (delEn |=> !slotUsed_ff[$past(hitIdx)])
        else $error("delete did not free slot");
    stray_item_a: assert property (take && isItem && state_ff == ST_IDLE |=> rsp_ff.cause == CAUSE_NOSESS)
        else $error("item outside session accepted");

    commit_seen_c: cover property (commitPulse);
    inf_answer_c: cover property (rsp_ff.valid && rsp_ff.kind == RSP_DEF);
    sess_abort_c: cover property (sessOpen ##1 rsp_ff.valid && rsp_ff.kind == RSP_ERR);
endmodule // cfx_session_handler

// ===== verif/cfx_peer_model.sv
// peer entity model that sends configuration messages and records answers
`timescale 1ns/10ps
`include "cfx_params.svh"
module cfx_peer_model (
    // clock
    input wire logic sys_clk,
    // message link
    input wire logic msgReady,
    output cfx_pkg::cfx_msg_t msgIn,
    input wire cfx_pkg::cfx_rsp_t rspOut,
    input wire logic commitPulse,
    // what came back at the taking edge, and the wait timeout flag
    output cfx_pkg::cfx_rsp_t seenRsp,
    output logic seenCommit,
    output logic seenReady,
    output logic hung
);
    import cfx_pkg::*;
    initial begin
        msgIn = '0;
        seenRsp = '0;
        seenCommit = 1'b0;
        seenReady = 1'b0;
        hung = 1'b0;
    end
    // ===========================================
    // one message, held until taken
    // sessions are opened with DEF, items follow in category order,
    // END closes after the announced items, all as the caller orders
    task automatic send(input cfx_cmd_t cmd, input logic [4:0] len,
        input logic [`CFX_NAME_BITS-1:0] name, input cfx_counts_t counts, input logic ok);
        int n;
        cfx_msg_t idle;
        @(negedge sys_clk);
        msgIn.valid = 1'b1;
        msgIn.cmd = cmd;
        msgIn.nameLen = len;
        msgIn.name = name;
        msgIn.counts = counts;
        msgIn.itemOk = ok;
        n = 0;
        while (msgReady !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 20) begin
            hung = 1'b1;
        end
        @(posedge sys_clk);
        #1;
        seenRsp = rspOut;
        seenCommit = commitPulse;
        seenReady = msgReady;
        @(negedge sys_clk);
        // released fields show no stale value
        idle = ~msgIn;
        idle.valid = 1'b0;
        msgIn = idle;
    endtask
endmodule // cfx_peer_model

// ===== verif/tb_cfx_session_handler.sv
// self-checking bench for the configuration exchange session handler
`timescale 1ns/10ps
`include "cfx_params.svh"
module tb_cfx_session_handler;
    import cfx_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [`CFX_SLOT_W-1:0] onAirSlot = 2'h0;
    logic reconfPending = 1'b0;
    logic [`CFX_SLOT_W-1:0] nextSlot = 2'h0;
    cfx_msg_t msgIn;
    logic msgReady;
    cfx_rsp_t rspOut;
    logic sessOpen;
    logic [`CFX_SLOTS-1:0] slotUsed;
    logic commitPulse;
    cfx_rsp_t seenRsp;
    logic seenCommit;
    logic seenReady;
    logic hung;
    int failures = 0;
    int checks = 0;
    int slotA = 0;
    always #2.5 sys_clk = ~sys_clk;
    cfx_session_handler cfx_session_handler_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .msgIn(msgIn), .msgReady(msgReady), .onAirSlot(onAirSlot),
        .reconfPending(reconfPending), .nextSlot(nextSlot), .rspOut(rspOut),
        .sessOpen(sessOpen), .slotUsed(slotUsed), .commitPulse(commitPulse));
    cfx_peer_model cfx_peer_model_inst (.sys_clk(sys_clk), .msgReady(msgReady), .msgIn(msgIn),
        .rspOut(rspOut), .commitPulse(commitPulse), .seenRsp(seenRsp),
        .seenCommit(seenCommit), .seenReady(seenReady), .hung(hung));
    // ===========================================
    // helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [`CFX_NAME_BITS-1:0] nm(input string s);
        nm = '0;
        for (int i = 0; i < s.len(); i++) begin
            nm[i*8+:8] = s[i];
        end
    endfunction
    function automatic cfx_counts_t cnt(input int c, input int s, input int p, input int v,
        input int f);
        cnt = '{chan:14'(c), strm:14'(s), comp:14'(p), serv:14'(v), figf:14'(f)};
    endfunction
    task automatic msg(input cfx_cmd_t cmd, input string s, input cfx_counts_t c, input logic ok);
        cfx_peer_model_inst.send(cmd, 5'(s.len()), nm(s), c, ok);
    endtask
    task automatic err(input cfx_cause_t c);
        chk("answer valid", 32'h1, seenRsp.valid);
        chk("answer kind", RSP_ERR, seenRsp.kind);
        chk("error cause", c, seenRsp.cause);
    endtask
    task automatic quiet();
        chk("no answer", 32'h0, seenRsp.valid);
    endtask
    task automatic results();
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge hung) begin
        failures++;
        results();
    end
    // ===========================================
    // scenarios
    task automatic t_reset();
        chk("reset rsp valid", 32'h0, rspOut.valid);
        chk("reset ready", 32'h1, msgReady);
        chk("reset session", 32'h0, sessOpen);
        chk("reset slots", 32'h0, slotUsed);
        chk("reset commit", 32'h0, commitPulse);
    endtask
    task automatic t_create();
        msg(CMD_DEF, "A", cnt(1, 1, 0, 0, 1), 1'b1);
        quiet();
        chk("session open", 32'h1, sessOpen);
        msg(CMD_SUBCHAN, "", '0, 1'b1);
        msg(CMD_USESTRM, "", '0, 1'b1);
        msg(CMD_USEFIGF, "", '0, 1'b1);
        chk("no early commit", 32'h0, seenCommit);
        msg(CMD_END, "", '0, 1'b1);
        chk("commit", 32'h1, seenCommit);
        chk("session closed", 32'h0, sessOpen);
        chk("slots in use", 32'h1, $countones(slotUsed));
        for (int i = 0; i < `CFX_SLOTS; i++) begin
            if (slotUsed[i] === 1'b1) begin
                slotA = i;
            end
        end
    endtask
    task automatic t_names();
        string bad[4] = '{"", "ABCDEFGHIJKLMNOPQ", "CURRENT", "NEXT"};
        for (int i = 0; i < 4; i++) begin
            msg(CMD_DEF, bad[i], '0, 1'b1);
            err(CAUSE_BADNAME);
        end
        msg(CMD_DEF, "A", '0, 1'b1);
        err(CAUSE_USED);
        msg(CMD_DEF, "ABCDEFGHIJKLMNOP", '0, 1'b1);
        quiet();
        msg(CMD_END, "", '0, 1'b1);
        chk("long name commit", 32'h1, seenCommit);
    endtask
    task automatic t_counts();
        cfx_counts_t over[5] = '{cnt(65, 0, 0, 0, 0), cnt(0, 2048, 0, 0, 0),
            cnt(0, 0, 10000, 0, 0), cnt(0, 0, 0, 10000, 0), cnt(0, 0, 0, 0, 65)};
        cfx_cause_t cz[5] = '{CAUSE_NCHAN, CAUSE_NSTRM, CAUSE_NCOMP, CAUSE_NSERV, CAUSE_NFIGF};
        for (int i = 0; i < 5; i++) begin
            msg(CMD_DEF, "B", over[i], 1'b1);
            err(cz[i]);
        end
        msg(CMD_DEF, "B", cnt(64, 0, 0, 0, 0), 1'b1);
        quiet();
        msg(CMD_END, "", '0, 1'b1);
        err(CAUSE_NCHAN);
        chk("no commit", 32'h0, seenCommit);
        msg(CMD_DEF, "B", cnt(0, 1, 0, 0, 0), 1'b1);
        msg(CMD_USESTRM, "", '0, 1'b1);
        msg(CMD_USESTRM, "", '0, 1'b1);
        err(CAUSE_NSTRM);
        chk("aborted", 32'h0, sessOpen);
    endtask
    task automatic t_order();
        msg(CMD_DEF, "C", cnt(1, 1, 0, 0, 0), 1'b1);
        msg(CMD_USESTRM, "", '0, 1'b1);
        msg(CMD_SUBCHAN, "", '0, 1'b1);
        err(CAUSE_SUBCHAN);
        chk("aborted", 32'h0, sessOpen);
        msg(CMD_END, "", '0, 1'b1);
        err(CAUSE_NOSESS);
        msg(CMD_SERVICE, "", '0, 1'b1);
        err(CAUSE_NOSESS);
        msg(CMD_DEF, "C", cnt(0, 0, 1, 0, 0), 1'b1);
        msg(CMD_CMPNENT, "", '0, 1'b0);
        err(CAUSE_CMPNENT);
        msg(CMD_DEF, "C", '0, 1'b1);
        msg(CMD_DEF, "D", '0, 1'b1);
        err(CAUSE_NOSESS);
        msg(CMD_DEF, "C", '0, 1'b1);
        msg(CMD_ERR, "C", '0, 1'b1);
        quiet();
        chk("peer abort", 32'h0, sessOpen);
        chk("slots kept", 32'h2, $countones(slotUsed));
    endtask
    task automatic inf_ok(input string s);
        msg(CMD_INF, s, '0, 1'b1);
        chk("def kind", RSP_DEF, seenRsp.kind);
        chk("def valid", 32'h1, seenRsp.valid);
        chk("def counts", 32'h1, seenRsp.counts === cnt(1, 1, 0, 0, 1));
        chk("def name", 32'h1, seenRsp.name === nm("A"));
        chk("ready gap", 32'h0, seenReady);
        @(posedge sys_clk);
        #1;
        chk("end valid", 32'h1, rspOut.valid);
        chk("end kind", RSP_END, rspOut.kind);
        chk("end name", 32'h1, rspOut.name === nm("A"));
    endtask
    task automatic t_inf();
        @(negedge sys_clk);
        onAirSlot = 2'(slotA);
        inf_ok("A");
        inf_ok("CURRENT");
        msg(CMD_INF, "NEXT", '0, 1'b1);
        err(CAUSE_UNKNOWN);
        @(negedge sys_clk);
        reconfPending = 1'b1;
        nextSlot = 2'(slotA);
        inf_ok("NEXT");
        msg(CMD_INF, "ZZ", '0, 1'b1);
        err(CAUSE_UNKNOWN);
    endtask
    task automatic t_del();
        msg(CMD_DEL, "A", '0, 1'b1);
        quiet();
        chk("deleted", 32'h0, slotUsed[slotA]);
        chk("other kept", 32'h1, $countones(slotUsed));
        msg(CMD_DEL, "A", '0, 1'b1);
        err(CAUSE_UNKNOWN);
        msg(CMD_INF, "A", '0, 1'b1);
        err(CAUSE_UNKNOWN);
        msg(CMD_DEL, "CURRENT", '0, 1'b1);
        err(CAUSE_UNKNOWN);
    endtask
    task automatic t_full();
        string more[3] = '{"E", "F", "G"};
        for (int i = 0; i < 3; i++) begin
            msg(CMD_DEF, more[i], '0, 1'b1);
            msg(CMD_END, "", '0, 1'b1);
            chk("fill commit", 32'h1, seenCommit);
        end
        chk("store full", 32'h4, $countones(slotUsed));
        msg(CMD_DEF, "H", '0, 1'b1);
        err(CAUSE_NOSPACE);
        chk("no session", 32'h0, sessOpen);
    endtask
    // ===========================================
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        t_reset();
        @(negedge sys_clk);
        sys_rst = 1'b0;
        t_create();
        t_names();
        t_counts();
        t_order();
        t_inf();
        t_del();
        t_full();
        results();
    end
endmodule // tb_cfx_session_handler
